// file: include/rrs_defs.svh
// Offsets, field positions and reset values of the receive status register bank
`ifndef RRS_DEFS_SVH
`define RRS_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define RRS_ADDR_W        12
`define RRS_OFS_CHECK     12'h400
`define RRS_OFS_MATCH     12'h408
`define RRS_OFS_CHKVAL    12'h40C
`define RRS_OFS_DAI       12'h410
`define RRS_OFS_PAYLOAD   12'h414
`define RRS_OFS_TONE      12'h44C
`define RRS_OFS_IRQ_STS   12'h600
`define RRS_OFS_IRQ_EN    12'h604
`define RRS_OFS_IRQ_CLR   12'h608

// ----------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------
`define RRS_LADDR_W       3
`define RRS_CHKVAL_W      24
`define RRS_DAI_W         3
`define RRS_LEN_W         8
`define RRS_RATE_LSB      1
`define RRS_RATE_W        2
`define RRS_TDUR_W        5
`define RRS_TRES_POS      5
`define RRS_TKIND_LSB     6
`define RRS_TKIND_W       2
`define RRS_IRQ_W         4
`define RRS_IRQ_DONE      0
`define RRS_IRQ_CHKERR    1
`define RRS_IRQ_RATE      2
`define RRS_IRQ_TONE      3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RRS_RST_WORD      32'h0000_0000
`define RRS_RST_IRQ       4'h0

`endif

// file: include/rrs_pkg.sv
// Types shared by the receive status register bank
package rrs_pkg;
  // Long range receive rate in force for the current frame
  typedef enum logic {
    RRS_RATE_LOW,
    RRS_RATE_HIGH
  } rrs_rate_t;

  typedef logic [31:0] rrs_word_t;
endpackage

// file: verilog/rrs_apb_slave.sv
// APB slave front end: registered read data and error, zero wait states while pclk_en stays high
`timescale 1ns/1ps
`default_nettype none
`include "rrs_defs.svh"
module rrs_apb_slave
  import rrs_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pclk_en,
  input  wire logic psel,
  input  wire logic penable,
  input  wire logic pwrite,
  input  wire rrs_word_t rd_data,
  input  wire logic addr_hit,
  output logic      pready,
  output rrs_word_t prdata,
  output logic      pslverr,
  output logic      wr_fire
);

  rrs_word_t prdata_reg;
  rrs_word_t prdata_next;
  logic      err_reg;
  logic      err_next;
  logic      taken_reg;
  logic      taken_next;
  logic      setup;
  logic      capture;

  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  // Answer only once the request is captured; a setup lost to a low enable costs a wait state
  assign pready  = pclk_en & taken_reg;
  assign setup   = psel & ~penable;
  assign capture = psel & ~taken_reg;
  assign wr_fire = psel & penable & pwrite & pready & ~err_reg;
  assign prdata  = prdata_reg;
  assign pslverr = err_reg;

  // Read data sampled in setup so it stands steady through the access phase
  always_comb begin
    prdata_next = prdata_reg;
    err_next    = err_reg;
    taken_next  = taken_reg;
    if (capture) begin
      prdata_next = (addr_hit && !pwrite) ? rd_data : `RRS_RST_WORD;
      err_next    = ~addr_hit;
      taken_next  = 1'b1;
    end
    // Transfer completes at the enabled edge with pready high
    if (psel && penable && taken_reg) begin
      taken_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= `RRS_RST_WORD;
      err_reg    <= 1'b0;
      taken_reg  <= 1'b0;
    end else if (pclk_en) begin
      prdata_reg <= prdata_next;
      err_reg    <= err_next;
      taken_reg  <= taken_next;
    end
  end

  // Unmapped address answers with an error in the access phase
  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && setup && !addr_hit |=> pslverr && prdata == `RRS_RST_WORD)
    else $error("unmapped access without error");

endmodule
`default_nettype wire

// file: verilog/rrs_status_regs.sv
// Receive status register bank: packet results, rate tracking, interrupts
`timescale 1ns/1ps
`default_nettype none
`include "rrs_defs.svh"
module rrs_status_regs
  import rrs_pkg::*;
#(
  parameter int LEN_W = `RRS_LEN_W
)
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     pclk_en,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`RRS_ADDR_W-1:0]   paddr,
  input  wire rrs_word_t                pwdata,
  input  wire logic [3:0]               pstrb,
  output logic                          pready,
  output rrs_word_t                     prdata,
  output logic                          pslverr,
  output logic                          irq,
  input  wire logic                     pkt_start,
  input  wire logic                     pkt_done,
  input  wire logic                     pkt_check_ok,
  input  wire logic [`RRS_LADDR_W-1:0]  matched_logical_address,
  input  wire logic [`RRS_CHKVAL_W-1:0] received_check_field,
  input  wire logic [`RRS_DAI_W-1:0]    device_address_match_index,
  input  wire logic [LEN_W-1:0]         pkt_payload_length,
  input  wire logic [LEN_W-1:0]         max_payload_length,
  input  wire logic                     long_range_mode,
  input  wire logic                     ci_received,
  input  wire logic                     ci_high_rate,
  input  wire logic                     cte_received,
  input  wire logic [`RRS_TDUR_W-1:0]   tone_extension_duration,
  input  wire logic                     reserved_parsed_bit,
  input  wire logic [`RRS_TKIND_W-1:0]  tone_extension_kind,
  output logic                          rate_change_event,
  output logic                          coding_rate_now
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic                     check_reg;
  logic                     check_next;
  logic [`RRS_LADDR_W-1:0]  match_reg;
  logic [`RRS_LADDR_W-1:0]  match_next;
  logic [`RRS_CHKVAL_W-1:0] chkval_reg;
  logic [`RRS_CHKVAL_W-1:0] chkval_next;
  logic [`RRS_DAI_W-1:0]    dai_reg;
  logic [`RRS_DAI_W-1:0]    dai_next;
  logic                     over_reg;
  logic                     over_next;
  logic [`RRS_RATE_W-1:0]   coding_rate_status_reg;
  logic [`RRS_RATE_W-1:0]   coding_rate_status_next;
  logic [`RRS_TDUR_W-1:0]   tdur_reg;
  logic [`RRS_TDUR_W-1:0]   tdur_next;
  logic                     tres_reg;
  logic                     tres_next;
  logic [`RRS_TKIND_W-1:0]  tkind_reg;
  logic [`RRS_TKIND_W-1:0]  tkind_next;
  rrs_rate_t                rate_reg;
  rrs_rate_t                rate_next;
  logic                     boost_reg;
  logic                     boost_next;
  logic [`RRS_IRQ_W-1:0]    sts_reg;
  logic [`RRS_IRQ_W-1:0]    sts_next;
  logic [`RRS_IRQ_W-1:0]    en_reg;
  logic [`RRS_IRQ_W-1:0]    en_next;
  logic                     irq_reg;
  logic                     irq_next;
  logic [`RRS_IRQ_W-1:0]    set_mask;
  logic [`RRS_IRQ_W-1:0]    clr_mask;
  logic                     boost_now;
  logic                     wr_fire;
  logic                     addr_hit;
  rrs_word_t                rd_data;

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  rrs_apb_slave u_apb (
    .pclk     (pclk),
    .presetn  (presetn),
    .pclk_en  (pclk_en),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .rd_data  (rd_data),
    .addr_hit (addr_hit),
    .pready   (pready),
    .prdata   (prdata),
    .pslverr  (pslverr),
    .wr_fire  (wr_fire)
  );

  // Address decode and read mux; reserved bits above each field read zero
  always_comb begin
    addr_hit = 1'b1;
    rd_data  = `RRS_RST_WORD;
    case (paddr)
      `RRS_OFS_CHECK:   rd_data[0] = check_reg;
      `RRS_OFS_MATCH:   rd_data[`RRS_LADDR_W-1:0] = match_reg;
      `RRS_OFS_CHKVAL:  rd_data[`RRS_CHKVAL_W-1:0] = chkval_reg;
      `RRS_OFS_DAI:     rd_data[`RRS_DAI_W-1:0] = dai_reg;
      `RRS_OFS_PAYLOAD: begin
        rd_data[0] = over_reg;
        rd_data[`RRS_RATE_LSB +: `RRS_RATE_W] = coding_rate_status_reg;
      end
      `RRS_OFS_TONE: begin
        rd_data[`RRS_TDUR_W-1:0] = tdur_reg;
        rd_data[`RRS_TRES_POS] = tres_reg;
        rd_data[`RRS_TKIND_LSB +: `RRS_TKIND_W] = tkind_reg;
      end
      `RRS_OFS_IRQ_STS: rd_data[`RRS_IRQ_W-1:0] = sts_reg;
      `RRS_OFS_IRQ_EN:  rd_data[`RRS_IRQ_W-1:0] = en_reg;
      `RRS_OFS_IRQ_CLR: rd_data = `RRS_RST_WORD;
      default:          addr_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Packet result capture
  // ----------------------------------------------------------------
  // Status registers have no write path at all, so bus writes cannot disturb them
  always_comb begin
    check_next  = check_reg;
    match_next  = match_reg;
    chkval_next = chkval_reg;
    dai_next    = dai_reg;
    over_next   = over_reg;
    coding_rate_status_next = coding_rate_status_reg;
    if (pkt_done) begin
      check_next  = pkt_check_ok;
      match_next  = matched_logical_address;
      chkval_next = received_check_field;
      dai_next    = device_address_match_index;
      over_next   = (pkt_payload_length > max_payload_length);
      // Outside long range the rate field has no meaning and reads zero
      coding_rate_status_next = (long_range_mode && rate_next == RRS_RATE_HIGH) ?
                    `RRS_RATE_W'(1) : `RRS_RATE_W'(0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      check_reg  <= 1'b0;
      match_reg  <= '0;
      chkval_reg <= '0;
      dai_reg    <= '0;
      over_reg   <= 1'b0;
      coding_rate_status_reg <= '0;
    end else if (pclk_en) begin
      check_reg  <= check_next;
      match_reg  <= match_next;
      chkval_reg <= chkval_next;
      dai_reg    <= dai_next;
      over_reg   <= over_next;
      coding_rate_status_reg <= coding_rate_status_next;
    end
  end

  // ----------------------------------------------------------------
  // Tone extension fields
  // ----------------------------------------------------------------
  always_comb begin
    tdur_next  = tdur_reg;
    tres_next  = tres_reg;
    tkind_next = tkind_reg;
    if (cte_received) begin
      tdur_next  = tone_extension_duration;
      tres_next  = reserved_parsed_bit;
      tkind_next = tone_extension_kind;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdur_reg  <= '0;
      tres_reg  <= 1'b0;
      tkind_reg <= '0;
    end else if (pclk_en) begin
      tdur_reg  <= tdur_next;
      tres_reg  <= tres_next;
      tkind_reg <= tkind_next;
    end
  end

  // ----------------------------------------------------------------
  // Long range rate tracking
  // ----------------------------------------------------------------
  // Each frame starts at the lower rate; the indicator can only raise it
  assign boost_now = long_range_mode && ci_received && ci_high_rate &&
                     rate_reg == RRS_RATE_LOW && !pkt_start;

  always_comb begin
    rate_next  = rate_reg;
    boost_next = 1'b0;
    case (rate_reg)
      RRS_RATE_LOW: begin
        if (boost_now) begin
          rate_next  = RRS_RATE_HIGH;
          boost_next = 1'b1;
        end
      end
      RRS_RATE_HIGH: begin
        if (pkt_start) begin
          rate_next = RRS_RATE_LOW;
        end
      end
      default: rate_next = RRS_RATE_LOW;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg  <= RRS_RATE_LOW;
      boost_reg <= 1'b0;
    end else if (pclk_en) begin
      rate_reg  <= rate_next;
      boost_reg <= boost_next;
    end
  end

  assign rate_change_event = boost_reg;
  assign coding_rate_now   = (rate_reg == RRS_RATE_HIGH);

  // ----------------------------------------------------------------
  // Interrupt status, enable and clear
  // ----------------------------------------------------------------
  always_comb begin
    set_mask = '0;
    set_mask[`RRS_IRQ_DONE]   = pkt_done;
    set_mask[`RRS_IRQ_CHKERR] = pkt_done & ~pkt_check_ok;
    set_mask[`RRS_IRQ_RATE]   = boost_next;
    set_mask[`RRS_IRQ_TONE]   = cte_received;
    clr_mask = '0;
    en_next  = en_reg;
    if (wr_fire && pstrb[0] && paddr == `RRS_OFS_IRQ_CLR) begin
      clr_mask = pwdata[`RRS_IRQ_W-1:0];
    end
    if (wr_fire && pstrb[0] && paddr == `RRS_OFS_IRQ_EN) begin
      en_next = pwdata[`RRS_IRQ_W-1:0];
    end
    // Set applied after clear so an event in the clearing cycle survives
    sts_next = (sts_reg & ~clr_mask) | set_mask;
    irq_next = |(sts_next & en_next);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_reg <= `RRS_RST_IRQ;
      en_reg  <= `RRS_RST_IRQ;
      irq_reg <= 1'b0;
    end else if (pclk_en) begin
      sts_reg <= sts_next;
      en_reg  <= en_next;
      irq_reg <= irq_next;
    end
  end

  assign irq = irq_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  check_result_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && pkt_done |=> check_reg == $past(pkt_check_ok))
    else $error("check result not captured");

  matched_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && pkt_done |=> match_reg == $past(matched_logical_address))
    else $error("matched address not captured");

  check_value_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && pkt_done ##1 (!pclk_en || !pkt_done)[*2] |->
    chkval_reg == $past(received_check_field, 2))
    else $error("check value not held");

  match_index_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && pkt_done |=> dai_reg == $past(device_address_match_index))
    else $error("match index not captured");

  payload_over_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && pkt_done |=>
    over_reg == ($past(pkt_payload_length) > $past(max_payload_length)))
    else $error("payload status wrong");

  rate_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && pkt_done |=> coding_rate_status_reg == ($past(long_range_mode) &&
    $past(rate_next) == RRS_RATE_HIGH ? 2'h1 : 2'h0))
    else $error("rate status wrong");

  tone_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && cte_received |=> tdur_reg == $past(tone_extension_duration) &&
    tres_reg == $past(reserved_parsed_bit) && tkind_reg == $past(tone_extension_kind))
    else $error("tone extension fields wrong");

  rate_boost_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && boost_now |=> rate_change_event && coding_rate_now ##1
    (!$past(pclk_en) || !rate_change_event))
    else $error("rate change missing or too long");

  write_ignored_a: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && wr_fire && !pkt_done |=> $stable(match_reg) && $stable(check_reg))
    else $error("status changed by a write");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(sts_reg & en_reg))
    else $error("interrupt level mismatch");

endmodule
`default_nettype wire

// file: verification/rrs_pkt_source.sv
// Behavioural packet engine model that feeds received frames into the status bank
`timescale 1ns/1ps
`default_nettype none
`include "rrs_defs.svh"
module rrs_pkt_source (
  input  wire logic                 pclk,
  output logic                      pkt_start,
  output logic                      pkt_done,
  output logic                      pkt_check_ok,
  output logic [`RRS_LADDR_W-1:0]   matched_logical_address,
  output logic [`RRS_CHKVAL_W-1:0]  received_check_field,
  output logic [`RRS_DAI_W-1:0]     device_address_match_index,
  output logic [7:0]                pkt_payload_length,
  output logic                      long_range_mode,
  output logic                      ci_received,
  output logic                      ci_high_rate,
  output logic                      cte_received,
  output logic [`RRS_TDUR_W-1:0]    tone_extension_duration,
  output logic                      reserved_parsed_bit,
  output logic [`RRS_TKIND_W-1:0]   tone_extension_kind
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  // Quiet line with no frame in flight
  initial begin
    {pkt_start, pkt_done, ci_received, cte_received, long_range_mode} = 5'h00;
    {pkt_check_ok, matched_logical_address, received_check_field} = 28'h0;
    {device_address_match_index, pkt_payload_length, ci_high_rate} = 12'h0;
    {tone_extension_duration, reserved_parsed_bit, tone_extension_kind} = 8'h0;
  end

  // ----------------------------------------------------------------
  // Frame events
  // ----------------------------------------------------------------
  // New frame: the rate falls back to the low coding
  task automatic frame_start(input logic lr);
    @(posedge pclk);
    long_range_mode <= lr;
    pkt_start <= 1'b1;
    @(posedge pclk);
    pkt_start <= 1'b0;
  endtask

  // Finished packet; fields are only valid with the strobe, so scramble them afterwards
  task automatic send_pkt(input logic ok, input logic [2:0] la, input logic [23:0] crc,
                          input logic [2:0] idx, input logic [7:0] len);
    @(posedge pclk);
    pkt_done <= 1'b1;
    {pkt_check_ok, matched_logical_address, received_check_field} <= {ok, la, crc};
    {device_address_match_index, pkt_payload_length} <= {idx, len};
    @(posedge pclk);
    pkt_done <= 1'b0;
    {pkt_check_ok, matched_logical_address, received_check_field} <= ~{ok, la, crc};
    {device_address_match_index, pkt_payload_length} <= ~{idx, len};
  endtask

  // Coding indicator field of a long range frame
  task automatic send_ci(input logic hr);
    @(posedge pclk);
    {ci_received, ci_high_rate} <= {1'b1, hr};
    @(posedge pclk);
    {ci_received, ci_high_rate} <= {1'b0, ~hr};
  endtask

  // Parsed tone extension information
  task automatic send_cte(input logic [4:0] dur, input logic res, input logic [1:0] kind);
    @(posedge pclk);
    {cte_received, tone_extension_duration, reserved_parsed_bit, tone_extension_kind} <= {1'b1, dur, res, kind};
    @(posedge pclk);
    {cte_received, tone_extension_duration, reserved_parsed_bit, tone_extension_kind} <= ~{1'b1, dur, res, kind};
  endtask
endmodule
`default_nettype wire

// file: verification/test_radio_rx_status_regs.sv
// Self-checking testbench for the receive status register bank
`timescale 1ns/1ps
`default_nettype none
`include "rrs_defs.svh"
module test_radio_rx_status_regs;
  import rrs_pkg::*;
  logic pclk, presetn, pclk_en, psel, penable, pwrite, pready, pslverr, irq;
  logic rate_change_event, coding_rate_now;
  logic [11:0] paddr;
  rrs_word_t   pwdata, prdata;
  logic [3:0]  pstrb;
  logic [7:0]  max_len;
  int          err_total, check_count;
  logic pkt_start, pkt_done, pkt_check_ok, long_range_mode, ci_received, ci_high_rate;
  logic cte_received, reserved_parsed_bit;
  logic [2:0]  matched_logical_address, device_address_match_index;
  logic [23:0] received_check_field;
  logic [7:0]  pkt_payload_length;
  logic [4:0]  tone_extension_duration;
  logic [1:0]  tone_extension_kind;

  // ----------------------------------------------------------------
  // Instances
  // ----------------------------------------------------------------
  rrs_status_regs #(.LEN_W(8)) dut_u (.pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq), .pkt_start(pkt_start), .pkt_done(pkt_done),
    .pkt_check_ok(pkt_check_ok), .matched_logical_address(matched_logical_address),
    .received_check_field(received_check_field), .device_address_match_index(device_address_match_index),
    .pkt_payload_length(pkt_payload_length), .max_payload_length(max_len), .long_range_mode(long_range_mode),
    .ci_received(ci_received), .ci_high_rate(ci_high_rate), .cte_received(cte_received),
    .tone_extension_duration(tone_extension_duration), .reserved_parsed_bit(reserved_parsed_bit),
    .tone_extension_kind(tone_extension_kind), .rate_change_event(rate_change_event),
    .coding_rate_now(coding_rate_now));
  rrs_pkt_source src_u (.pclk(pclk), .pkt_start(pkt_start), .pkt_done(pkt_done),
    .pkt_check_ok(pkt_check_ok), .matched_logical_address(matched_logical_address),
    .received_check_field(received_check_field), .device_address_match_index(device_address_match_index),
    .pkt_payload_length(pkt_payload_length), .long_range_mode(long_range_mode),
    .ci_received(ci_received), .ci_high_rate(ci_high_rate), .cte_received(cte_received),
    .tone_extension_duration(tone_extension_duration), .reserved_parsed_bit(reserved_parsed_bit),
    .tone_extension_kind(tone_extension_kind));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is seen high, bounded wait
  task automatic apb(input logic w, input logic [11:0] a, input rrs_word_t wd, output rrs_word_t rdv,
                     output logic er);
    int n;
    n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin
      err_total++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [11:0] a, input rrs_word_t e, input logic ee);
    rrs_word_t d;
    logic er;
    apb(1'b0, a, 32'h0000_0000, d, er);
    check($sformatf("prdata at %h", a), d, e);
    check($sformatf("pslverr at %h", a), {31'h0, er}, {31'h0, ee});
  endtask

  task automatic wr(input logic [11:0] a, input rrs_word_t d, input logic ee);
    rrs_word_t x;
    logic er;
    apb(1'b1, a, d, x, er);
    check($sformatf("write pslverr at %h", a), {31'h0, er}, {31'h0, ee});
  endtask

  // Lets a register write reach the registered interrupt line
  task automatic settle_irq(input logic e);
    repeat (2) @(posedge pclk);
    #1 check("irq", {31'h0, irq}, {31'h0, e});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Zero after reset, status writes dropped, unmapped places refused
  task automatic t_reset();
    logic [11:0] offs [9];
    offs = '{`RRS_OFS_CHECK, `RRS_OFS_MATCH, `RRS_OFS_CHKVAL, `RRS_OFS_DAI, `RRS_OFS_PAYLOAD,
             `RRS_OFS_TONE, `RRS_OFS_IRQ_STS, `RRS_OFS_IRQ_EN, `RRS_OFS_IRQ_CLR};
    for (int i = 0; i < 9; i++) begin
      rd(offs[i], 32'h0000_0000, 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      wr(offs[i], 32'hFFFF_FFFF, 1'b0);
      rd(offs[i], 32'h0000_0000, 1'b0);
    end
    rd(12'h004, 32'h0000_0000, 1'b1);
    wr(12'h700, 32'hFFFF_FFFF, 1'b1);
    check("coding_rate_now", {31'h0, coding_rate_now}, 32'h0);
    $display("test reset done");
  endtask

  // Good packet over length, bad at the limit, good below it
  task automatic t_packet();
    src_u.send_pkt(1'b1, 3'h5, 24'hABCDEF, 3'h6, 8'h11);
    rd(`RRS_OFS_CHECK, 32'h0000_0001, 1'b0);
    rd(`RRS_OFS_MATCH, 32'h0000_0005, 1'b0);
    rd(`RRS_OFS_CHKVAL, 32'h00AB_CDEF, 1'b0);
    rd(`RRS_OFS_DAI, 32'h0000_0006, 1'b0);
    rd(`RRS_OFS_PAYLOAD, 32'h0000_0001, 1'b0);
    src_u.send_pkt(1'b0, 3'h2, 24'h123456, 3'h1, 8'h10);
    rd(`RRS_OFS_CHECK, 32'h0000_0000, 1'b0);
    rd(`RRS_OFS_MATCH, 32'h0000_0002, 1'b0);
    rd(`RRS_OFS_CHKVAL, 32'h0012_3456, 1'b0);
    rd(`RRS_OFS_DAI, 32'h0000_0001, 1'b0);
    rd(`RRS_OFS_PAYLOAD, 32'h0000_0000, 1'b0);
    src_u.send_pkt(1'b1, 3'h7, 24'hFFFFFF, 3'h7, 8'h0F);
    rd(`RRS_OFS_PAYLOAD, 32'h0000_0000, 1'b0);
    rd(`RRS_OFS_CHKVAL, 32'h00FF_FFFF, 1'b0);
    max_len <= 8'h04;
    src_u.send_pkt(1'b1, 3'h7, 24'hFFFFFF, 3'h7, 8'h05);
    rd(`RRS_OFS_PAYLOAD, 32'h0000_0001, 1'b0);
    max_len <= 8'h10;
    $display("test packet done");
  endtask

  // Rate boost inside a long range frame, return to low at frame start
  task automatic t_rate();
    src_u.frame_start(1'b1);
    src_u.send_ci(1'b1);
    #1 check("rate_change_event", {31'h0, rate_change_event}, 32'h1);
    check("coding_rate_now", {31'h0, coding_rate_now}, 32'h1);
    @(posedge pclk);
    #1 check("rate_change_event", {31'h0, rate_change_event}, 32'h0);
    src_u.send_pkt(1'b1, 3'h1, 24'h000001, 3'h0, 8'h05);
    rd(`RRS_OFS_PAYLOAD, 32'h0000_0002, 1'b0);
    src_u.frame_start(1'b1);
    #1 check("coding_rate_now", {31'h0, coding_rate_now}, 32'h0);
    src_u.send_ci(1'b0);
    src_u.send_pkt(1'b1, 3'h1, 24'h000001, 3'h0, 8'h05);
    rd(`RRS_OFS_PAYLOAD, 32'h0000_0000, 1'b0);
    src_u.frame_start(1'b0);
    src_u.send_ci(1'b1);
    #1 check("rate_change_event", {31'h0, rate_change_event}, 32'h0);
    check("coding_rate_now", {31'h0, coding_rate_now}, 32'h0);
    $display("test rate done");
  endtask

  // Every tone kind, with duration and reserved bit varied alongside
  task automatic t_tone();
    logic [1:0] k;
    logic [4:0] d;
    for (int i = 0; i < 4; i++) begin
      k = 2'(i);
      d = 5'h1F - 5'(i * 7);
      src_u.send_cte(d, k[0], k);
      rd(`RRS_OFS_TONE, {24'h0, k, k[0], d}, 1'b0);
    end
    $display("test tone done");
  endtask

  // Raise, mask and clear the interrupt
  task automatic t_irq();
    wr(`RRS_OFS_IRQ_CLR, 32'h0000_000F, 1'b0);
    rd(`RRS_OFS_IRQ_STS, 32'h0000_0000, 1'b0);
    wr(`RRS_OFS_IRQ_EN, 32'h0000_0001, 1'b0);
    settle_irq(1'b0);
    src_u.send_pkt(1'b1, 3'h3, 24'h00C0DE, 3'h2, 8'h01);
    settle_irq(1'b1);
    rd(`RRS_OFS_IRQ_STS, 32'h0000_0001, 1'b0);
    wr(`RRS_OFS_IRQ_EN, 32'h0000_0002, 1'b0);
    settle_irq(1'b0);
    src_u.send_pkt(1'b0, 3'h3, 24'h00C0DE, 3'h2, 8'h01);
    settle_irq(1'b1);
    rd(`RRS_OFS_IRQ_STS, 32'h0000_0003, 1'b0);
    wr(`RRS_OFS_IRQ_CLR, 32'h0000_0002, 1'b0);
    settle_irq(1'b0);
    rd(`RRS_OFS_IRQ_STS, 32'h0000_0001, 1'b0);
    rd(`RRS_OFS_IRQ_EN, 32'h0000_0002, 1'b0);
    pstrb <= 4'hE;
    wr(`RRS_OFS_IRQ_EN, 32'h0000_000F, 1'b0);
    rd(`RRS_OFS_IRQ_EN, 32'h0000_0002, 1'b0);
    pstrb <= 4'hF;
    rd(`RRS_OFS_CHECK, 32'h0000_0000, 1'b0);
    $display("test irq done");
  endtask

  // Frozen enable: a packet is dropped and a read stalls until the enable returns
  task automatic t_freeze();
    pclk_en <= 1'b0;
    src_u.send_pkt(1'b1, 3'h4, 24'h5A5A5A, 3'h3, 8'h20);
    fork
      rd(`RRS_OFS_MATCH, 32'h0000_0003, 1'b0);
      begin
        repeat (3) @(posedge pclk);
        pclk_en <= 1'b1;
      end
    join
    rd(`RRS_OFS_CHECK, 32'h0000_0000, 1'b0);
    rd(`RRS_OFS_IRQ_STS, 32'h0000_0001, 1'b0);
    $display("test freeze done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {pclk, presetn, pclk_en, psel, penable, pwrite} = 6'b001000;
    {paddr, pwdata, pstrb, max_len} = {12'h000, 32'h0000_0000, 4'hF, 8'h10};
    {err_total, check_count} = {32'sd0, 32'sd0};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_packet();
    t_rate();
    t_tone();
    t_irq();
    t_freeze();
    report_and_stop();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
